/* verilog/cesf_regs.svh */
// Constants for the early-stage charger state machine: state codes, reset values.
// Assumes inclusion by bare name from the package and the main module.
`ifndef CESF_REGS_SVH
`define CESF_REGS_SVH
`define CESF_CODE_OFF 4'h0
`define CESF_CODE_IDLE 4'h1
`define CESF_CODE_PRECHG 4'h2
`define CESF_CODE_CC1 4'h3
`define CESF_CODE_CC2 4'h4
`define CESF_CODE_PCHG_FAULT 4'h8
`define CESF_CODE_SAFE_FAULT 4'h9
`define CESF_CODE_SUSPEND 4'ha
`define CESF_CODE_BOOT 4'hb
`define CESF_CODE_FORCE 4'hc
`define CESF_STEP_EN_RST 1'b1
`define CESF_ROOM_ONLY_RST 1'b0
`define CESF_BOOT_CYCLES 4'h4
`endif

/* verilog/cesf_pkg.sv */
// Types for the early-stage charger state machine.
// Assumes cesf_regs.svh on the include path.
`include "cesf_regs.svh"
package cesf_pkg;
   typedef enum logic [1:0] {
      CESF_ZONE_ROOM = 2'h0,
      CESF_ZONE_COOL = 2'h1,
      CESF_ZONE_WARM = 2'h2,
      CESF_ZONE_OTHER = 2'h3
   } cesf_zone_e;
   typedef enum logic [1:0] {
      CESF_CUR_NONE = 2'h0,
      CESF_CUR_PRECHG = 2'h1,
      CESF_CUR_CC1 = 2'h2,
      CESF_CUR_CC2 = 2'h3
   } cesf_cur_e;
   typedef enum logic [8:0] {
      CESF_ST_OFF = 9'h001,
      CESF_ST_IDLE = 9'h002,
      CESF_ST_BOOT = 9'h004,
      CESF_ST_PRECHG = 9'h008,
      CESF_ST_FORCE = 9'h010,
      CESF_ST_CC1 = 9'h020,
      CESF_ST_CC2 = 9'h040,
      CESF_ST_FAULT = 9'h080,
      CESF_ST_SUSPEND = 9'h100
   } cesf_state_e;
   // Synchronous comparator results from the analog front end
   typedef struct packed {
      logic below_recharge;
      logic below_precharge;
      logic at_step_rise;
      logic sys_at_min;
   } cesf_cmp_s;
   typedef struct packed {
      logic charger_enable;
      logic auto_restart_enable;
      logic skip_recharge_start;
      logic force_precharge;
      logic first_stage_timeout_enable;
      logic charger_reg_reset_enable;
   } cesf_cfg_s;
   typedef struct packed {
      logic precharge_timer;
      logic global_safety_timer;
      logic step_charge_timer;
   } cesf_tmr_s;
endpackage

/* verilog/cesf_sync3.sv */
// Three-stage synchroniser for a level from outside the clock domain.
// Output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module cesf_sync3 (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_async,
   output logic o_level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic out_reg;
   logic out_next;
   always_comb begin
      out_next = out_reg;
      if (s2_reg == s3_reg) begin
         out_next = s3_reg;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         out_reg <= 1'b0;
      end else begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end
   assign o_level = out_reg;
endmodule
`default_nettype wire

/* verilog/cesf_top.sv */
// Early-stage charger control: off, idle, boot, precharge, forced precharge, CC1.
// Assumes comparators, timers and temperature zone come synchronous from the analog side;
// the line-power detect is a pin and is synchronised here.
//
// Operation
// - Link connection seen while off moves the machine to idle.
// - Line power present with charger disabled forces and holds idle from every state except off.
// - Leave idle for boot: not link idle, enabled, below recharge or skip set.
// - Link idle ends itself when enabled, auto-restart on, battery below recharge.
// - Entering boot pulses a reset to every charger timer.
// - Boot with register-reset enable pulses a reset of charger registers.
// - Boot done with system rail at minimum enters precharge, code 0010.
// - Precharge requests precharge current; stays while below threshold and not forced.
// - Rise above precharge threshold enters CC1 if step on, step-done clear and room allowed.
// - Rise goes to CC2 if step off, step-done set or room-only outside room zone.
// - Precharge timer expiry enters precharge fault, code 1000, suspends charge.
// - Safety timer expiry in precharge or CC1 gives fault code 1001.
// - Temperature disable in precharge or CC1 suspends charging.
// - Force bit holds forced precharge; clearing it returns through boot.
// - CC1 requests at most the programmed CC1 current.
// - CC1 reaching the step-rise threshold moves to CC2.
// - Drop below precharge in CC1 returns to precharge, sets step-done.
// - CC1 timeout enabled and step timer expired moves to CC2.
// - Room-only set and zone leaving room during CC1 moves to CC2.
// - Step enable resets to 1, room-only resets to 0.
// - Code 0000 when off, 0001 when idle.
`timescale 1ns/1ps
`default_nettype none
`include "cesf_regs.svh"
module cesf_top (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_link_connect,
   input wire logic i_line_power_pin,
   input wire logic i_link_idle_mode,
   input wire logic i_temp_disable,
   input wire cesf_pkg::cesf_zone_e i_temp_zone,
   input wire cesf_pkg::cesf_cmp_s i_cmp,
   input wire cesf_pkg::cesf_cfg_s i_cfg,
   input wire cesf_pkg::cesf_tmr_s i_tmr_expired,
   input wire logic i_step_en_wr,
   input wire logic i_step_en_wdata,
   input wire logic i_room_only_wr,
   input wire logic i_room_only_wdata,
   output logic [3:0] o_charger_state_code,
   output cesf_pkg::cesf_cur_e o_current_select,
   output logic o_timer_reset,
   output logic o_charger_reg_reset,
   output logic o_link_idle_exit,
   output logic o_step_charging_enable,
   output logic o_first_stage_room_only,
   output logic o_step_done_flag
);
   logic line_power;
   cesf_pkg::cesf_state_e st_reg;
   cesf_pkg::cesf_state_e st_next;
   logic [3:0] code_reg;
   logic [3:0] code_next;
   cesf_pkg::cesf_cur_e cur_reg;
   cesf_pkg::cesf_cur_e cur_next;
   logic [3:0] boot_cnt_reg;
   logic [3:0] boot_cnt_next;
   logic tmr_rst_reg;
   logic tmr_rst_next;
   logic creg_rst_reg;
   logic creg_rst_next;
   logic idle_exit_reg;
   logic idle_exit_next;
   logic step_en_reg;
   logic step_en_next;
   logic room_only_reg;
   logic room_only_next;
   logic step_done_reg;
   logic step_done_next;
   logic in_room_reg;
   logic in_room_next;
   logic fault_safe_reg;
   logic fault_safe_next;

   // Line power is a pin; a late edge on it must not split one decision across two cycles
   cesf_sync3 u_power_sync (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_async(i_line_power_pin),
      .o_level(line_power)
   );

   function automatic cesf_pkg::cesf_state_e rise_target(input logic step_en,
         input logic room_only, input logic step_done, input cesf_pkg::cesf_zone_e zone);
      if (step_en && !step_done && (!room_only || zone == cesf_pkg::CESF_ZONE_ROOM)) begin
         rise_target = cesf_pkg::CESF_ST_CC1;
      end else begin
         rise_target = cesf_pkg::CESF_ST_CC2;
      end
   endfunction

   function automatic logic [3:0] code_of(input cesf_pkg::cesf_state_e st, input logic safe);
      unique case (st)
         cesf_pkg::CESF_ST_OFF: code_of = `CESF_CODE_OFF;
         cesf_pkg::CESF_ST_IDLE: code_of = `CESF_CODE_IDLE;
         cesf_pkg::CESF_ST_BOOT: code_of = `CESF_CODE_BOOT;
         cesf_pkg::CESF_ST_PRECHG: code_of = `CESF_CODE_PRECHG;
         cesf_pkg::CESF_ST_FORCE: code_of = `CESF_CODE_FORCE;
         cesf_pkg::CESF_ST_CC1: code_of = `CESF_CODE_CC1;
         cesf_pkg::CESF_ST_CC2: code_of = `CESF_CODE_CC2;
         cesf_pkg::CESF_ST_FAULT: begin
            if (safe) begin
               code_of = `CESF_CODE_SAFE_FAULT;
            end else begin
               code_of = `CESF_CODE_PCHG_FAULT;
            end
         end
         cesf_pkg::CESF_ST_SUSPEND: code_of = `CESF_CODE_SUSPEND;
         default: code_of = `CESF_CODE_OFF;
      endcase
   endfunction

   // Step and room-only configuration bits; boot with register reset restores them
   always_comb begin
      step_en_next = step_en_reg;
      room_only_next = room_only_reg;
      if (i_step_en_wr) begin
         step_en_next = i_step_en_wdata;
      end
      if (i_room_only_wr) begin
         room_only_next = i_room_only_wdata;
      end
      if (creg_rst_next) begin
         step_en_next = `CESF_STEP_EN_RST;
         room_only_next = `CESF_ROOM_ONLY_RST;
      end
   end

   always_comb begin
      st_next = st_reg;
      boot_cnt_next = boot_cnt_reg;
      tmr_rst_next = 1'b0;
      creg_rst_next = 1'b0;
      idle_exit_next = 1'b0;
      step_done_next = step_done_reg;
      fault_safe_next = fault_safe_reg;
      in_room_next = (i_temp_zone == cesf_pkg::CESF_ZONE_ROOM);
      unique case (st_reg)
         cesf_pkg::CESF_ST_OFF: begin
            if (i_link_connect) begin
               st_next = cesf_pkg::CESF_ST_IDLE;
            end
         end
         cesf_pkg::CESF_ST_IDLE: begin
            // Recharge comparison is a registered input, so this decides within a cycle
            if (i_link_idle_mode && i_cfg.charger_enable && i_cfg.auto_restart_enable &&
                  i_cmp.below_recharge) begin
               idle_exit_next = 1'b1;
            end
            if (!i_link_idle_mode && i_cfg.charger_enable &&
                  (i_cmp.below_recharge || i_cfg.skip_recharge_start)) begin
               st_next = cesf_pkg::CESF_ST_BOOT;
               tmr_rst_next = 1'b1;
               creg_rst_next = i_cfg.charger_reg_reset_enable;
               boot_cnt_next = 4'h0;
               // A fresh charge cycle may use CC1 again
               step_done_next = 1'b0;
            end
         end
         cesf_pkg::CESF_ST_BOOT: begin
            // A fixed count lets the timer and register resets settle before precharge
            if (boot_cnt_reg != `CESF_BOOT_CYCLES) begin
               boot_cnt_next = boot_cnt_reg + 4'h1;
            end else if (i_cmp.sys_at_min) begin
               st_next = cesf_pkg::CESF_ST_PRECHG;
            end
         end
         cesf_pkg::CESF_ST_PRECHG: begin
            if (i_tmr_expired.global_safety_timer) begin
               st_next = cesf_pkg::CESF_ST_FAULT;
               fault_safe_next = 1'b1;
            end else if (i_tmr_expired.precharge_timer) begin
               st_next = cesf_pkg::CESF_ST_FAULT;
               fault_safe_next = 1'b0;
            end else if (i_temp_disable) begin
               st_next = cesf_pkg::CESF_ST_SUSPEND;
            end else if (i_cfg.force_precharge) begin
               st_next = cesf_pkg::CESF_ST_FORCE;
            end else if (!i_cmp.below_precharge) begin
               st_next = rise_target(step_en_reg, room_only_reg, step_done_reg, i_temp_zone);
            end
         end
         cesf_pkg::CESF_ST_FORCE: begin
            // Forced precharge ends through boot so every timer restarts cleanly
            if (!i_cfg.force_precharge) begin
               st_next = cesf_pkg::CESF_ST_BOOT;
               tmr_rst_next = 1'b1;
               creg_rst_next = i_cfg.charger_reg_reset_enable;
               boot_cnt_next = 4'h0;
            end
         end
         cesf_pkg::CESF_ST_CC1: begin
            if (i_tmr_expired.global_safety_timer) begin
               st_next = cesf_pkg::CESF_ST_FAULT;
               fault_safe_next = 1'b1;
            end else if (i_temp_disable) begin
               st_next = cesf_pkg::CESF_ST_SUSPEND;
            end else if (i_cmp.below_precharge) begin
               // CC1-done and CC2 are passed through in one step to precharge
               st_next = cesf_pkg::CESF_ST_PRECHG;
               step_done_next = 1'b1;
            end else if (i_cmp.at_step_rise) begin
               st_next = cesf_pkg::CESF_ST_CC2;
            end else if (i_cfg.first_stage_timeout_enable && i_tmr_expired.step_charge_timer) begin
               st_next = cesf_pkg::CESF_ST_CC2;
            // Room exit compares the zone of the last cycle with that of this cycle
            end else if (room_only_reg && in_room_reg && !in_room_next) begin
               st_next = cesf_pkg::CESF_ST_CC2;
            end
         end
         // CC2 onward is handled downstream, but a drop below precharge returns CC2 to precharge; faults and suspension are held here
         cesf_pkg::CESF_ST_CC2: begin
            if (i_cmp.below_precharge) begin
               st_next = cesf_pkg::CESF_ST_PRECHG;
            end
         end
         cesf_pkg::CESF_ST_FAULT: begin
         end
         cesf_pkg::CESF_ST_SUSPEND: begin
         end
         default: st_next = cesf_pkg::CESF_ST_OFF;
      endcase
      // Disable under line power wins over every transition, boot pulses included
      if (st_reg != cesf_pkg::CESF_ST_OFF && line_power && !i_cfg.charger_enable) begin
         st_next = cesf_pkg::CESF_ST_IDLE;
         tmr_rst_next = 1'b0;
         creg_rst_next = 1'b0;
      end
   end

   // Outputs come from the next state so the code never lags the state by a cycle
   always_comb begin
      code_next = code_of(st_next, fault_safe_next);
      unique case (st_next)
         cesf_pkg::CESF_ST_PRECHG, cesf_pkg::CESF_ST_FORCE: begin
            cur_next = cesf_pkg::CESF_CUR_PRECHG;
         end
         cesf_pkg::CESF_ST_CC1: cur_next = cesf_pkg::CESF_CUR_CC1;
         cesf_pkg::CESF_ST_CC2: cur_next = cesf_pkg::CESF_CUR_CC2;
         default: cur_next = cesf_pkg::CESF_CUR_NONE;
      endcase
   end

   // Configuration bits
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         step_en_reg <= `CESF_STEP_EN_RST;
         room_only_reg <= `CESF_ROOM_ONLY_RST;
      end else begin
         step_en_reg <= step_en_next;
         room_only_reg <= room_only_next;
      end
   end

   // Control state and its one-cycle pulses
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         st_reg <= cesf_pkg::CESF_ST_OFF;
         boot_cnt_reg <= 4'h0;
         tmr_rst_reg <= 1'b0;
         creg_rst_reg <= 1'b0;
         idle_exit_reg <= 1'b0;
         step_done_reg <= 1'b0;
         in_room_reg <= 1'b1;
         fault_safe_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         boot_cnt_reg <= boot_cnt_next;
         tmr_rst_reg <= tmr_rst_next;
         creg_rst_reg <= creg_rst_next;
         idle_exit_reg <= idle_exit_next;
         step_done_reg <= step_done_next;
         in_room_reg <= in_room_next;
         fault_safe_reg <= fault_safe_next;
      end
   end

   // State code and current selection
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         code_reg <= `CESF_CODE_OFF;
         cur_reg <= cesf_pkg::CESF_CUR_NONE;
      end else begin
         code_reg <= code_next;
         cur_reg <= cur_next;
      end
   end

   assign o_charger_state_code = code_reg;
   assign o_current_select = cur_reg;
   assign o_timer_reset = tmr_rst_reg;
   assign o_charger_reg_reset = creg_rst_reg;
   assign o_link_idle_exit = idle_exit_reg;
   assign o_step_charging_enable = step_en_reg;
   assign o_first_stage_room_only = room_only_reg;
   assign o_step_done_flag = step_done_reg;
endmodule
`default_nettype wire

/* tb/cesf_afe_model.sv */
// Behavioural analog front end: battery and system rail comparators.
// Assumes the bench sets both rail voltages in millivolts.
`timescale 1ns/1ps
`default_nettype none
module cesf_afe_model #(
   parameter logic [15:0] REG_MV = 16'h1068,
   parameter logic [15:0] RECHG_OFS_MV = 16'h0064,
   parameter logic [15:0] PCHG_MV = 16'h0bb8,
   parameter logic [15:0] STEP_MV = 16'h0fa0,
   parameter logic [15:0] SYS_MIN_MV = 16'h0d48
) (
   input wire logic i_sys_clk,
   input wire logic [15:0] i_vbat_mv,
   input wire logic [15:0] i_vsys_mv,
   output cesf_pkg::cesf_cmp_s o_cmp
);
   // Registered so the state machine never sees a comparator change mid-cycle
   always_ff @(posedge i_sys_clk) begin
      o_cmp.below_recharge <= i_vbat_mv < (REG_MV - RECHG_OFS_MV);
      o_cmp.below_precharge <= i_vbat_mv < PCHG_MV;
      o_cmp.at_step_rise <= i_vbat_mv >= STEP_MV;
      o_cmp.sys_at_min <= i_vsys_mv >= SYS_MIN_MV;
   end
endmodule
`default_nettype wire

/* tb/cesf_top_assertions.sv */
// Checker for the early-stage charger state machine.
// Assumes it is bound to cesf_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cesf_top_assertions (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_link_connect,
   input wire logic i_link_idle_mode,
   input wire logic i_temp_disable,
   input wire cesf_pkg::cesf_cmp_s i_cmp,
   input wire cesf_pkg::cesf_cfg_s i_cfg,
   input wire cesf_pkg::cesf_tmr_s i_tmr_expired,
   input wire logic [3:0] o_charger_state_code,
   input wire cesf_pkg::cesf_cur_e o_current_select,
   input wire logic o_timer_reset,
   input wire logic o_charger_reg_reset,
   input wire logic o_link_idle_exit,
   input wire logic o_step_charging_enable,
   input wire logic o_first_stage_room_only,
   input wire logic o_step_done_flag
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   logic [3:0] st;
   logic en;
   logic sft;
   assign st = o_charger_state_code;
   // Enable held high keeps the line-power override out of every antecedent that requires en high
   assign en = i_cfg.charger_enable;
   assign sft = i_tmr_expired.global_safety_timer;
   a_off_to_idle:
   assert property (st == 4'h0 && i_link_connect |=> st == 4'h1) else $error("no idle");
   a_idle_held:
   assert property (st == 4'h1 && !en |=> st == 4'h1) else $error("idle left");
   a_boot_entry:
   assert property (st == 4'h1 && en && !i_link_idle_mode &&
      (i_cmp.below_recharge || i_cfg.skip_recharge_start) |=> st == 4'hb && o_timer_reset)
      else $error("no boot");
   a_reg_reset_pair:
   assert property (o_charger_reg_reset |-> o_timer_reset && st == 4'hb) else $error("reg reset");
   a_link_idle_exit:
   assert property (st == 4'h1 && en && i_link_idle_mode && i_cfg.auto_restart_enable &&
      i_cmp.below_recharge |=> o_link_idle_exit) else $error("no idle exit");
   a_pchg_current:
   assert property (st == 4'h2 |-> o_current_select == cesf_pkg::CESF_CUR_PRECHG)
      else $error("precharge current");
   a_cc1_current:
   assert property (st == 4'h3 |-> o_current_select == cesf_pkg::CESF_CUR_CC1)
      else $error("cc1 current");
   a_pchg_fault:
   assert property (st == 4'h2 && en && !sft && i_tmr_expired.precharge_timer |=> st == 4'h8)
      else $error("no precharge fault");
   a_safety_fault:
   assert property (st inside {4'h2, 4'h3} && en && sft |=> st == 4'h9) else $error("no fault");
   a_temp_suspend:
   assert property (st inside {4'h2, 4'h3} && en && !sft && !i_tmr_expired.precharge_timer &&
      i_temp_disable |=> st == 4'ha) else $error("no suspend");
   a_step_rise:
   assert property (st == 4'h3 && en && !sft && !i_temp_disable && !i_cmp.below_precharge &&
      i_cmp.at_step_rise |=> st == 4'h4) else $error("no cc2");
   a_cc1_drop:
   assert property (st == 4'h3 && en && !sft && !i_temp_disable && i_cmp.below_precharge
      |=> st == 4'h2 && o_step_done_flag) else $error("no drop");
   a_force_exit:
   assert property (st == 4'hc && en && !i_cfg.force_precharge |=> st == 4'hb && o_timer_reset)
      else $error("no boot after force");
   a_reset_values:
   assert property (disable iff (1'b0) i_srst |=> st == 4'h0 && o_step_charging_enable &&
      !o_first_stage_room_only) else $error("reset values");
endmodule
bind cesf_top cesf_top_assertions i_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
   .i_link_connect(i_link_connect), .i_link_idle_mode(i_link_idle_mode),
   .i_temp_disable(i_temp_disable), .i_cmp(i_cmp), .i_cfg(i_cfg),
   .i_tmr_expired(i_tmr_expired), .o_charger_state_code(o_charger_state_code),
   .o_current_select(o_current_select), .o_timer_reset(o_timer_reset),
   .o_charger_reg_reset(o_charger_reg_reset), .o_link_idle_exit(o_link_idle_exit),
   .o_step_charging_enable(o_step_charging_enable),
   .o_first_stage_room_only(o_first_stage_room_only), .o_step_done_flag(o_step_done_flag));
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the early-stage charger state machine.
// Assumes cesf_pkg, cesf_top and the front-end model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, srst, link_conn, line_pwr, link_idle, temp_dis;
   logic sen_wr, sen_wd, rom_wr, rom_wd, tres, rres, lexit, sen, rom, sdone;
   logic [3:0] code;
   logic [15:0] vbat, vsys;
   cesf_pkg::cesf_zone_e zone;
   cesf_pkg::cesf_cmp_s cmp;
   cesf_pkg::cesf_cfg_s cfg;
   cesf_pkg::cesf_tmr_s tmr;
   cesf_pkg::cesf_cur_e cur;
   int n_fail = 0;
   int n_tests = 0;
   cesf_top i_dut (.i_sys_clk(clk), .i_srst(srst), .i_link_connect(link_conn),
      .i_line_power_pin(line_pwr), .i_link_idle_mode(link_idle), .i_temp_disable(temp_dis),
      .i_temp_zone(zone), .i_cmp(cmp), .i_cfg(cfg), .i_tmr_expired(tmr),
      .i_step_en_wr(sen_wr), .i_step_en_wdata(sen_wd), .i_room_only_wr(rom_wr),
      .i_room_only_wdata(rom_wd), .o_charger_state_code(code), .o_current_select(cur),
      .o_timer_reset(tres), .o_charger_reg_reset(rres), .o_link_idle_exit(lexit),
      .o_step_charging_enable(sen), .o_first_stage_room_only(rom), .o_step_done_flag(sdone));
   cesf_afe_model i_afe (.i_sys_clk(clk), .i_vbat_mv(vbat), .i_vsys_mv(vsys), .o_cmp(cmp));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Drives land on the rising edge; reads there see what the previous edge launched
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Bounded wait: the line-power synchroniser and boot both add a few cycles
   task automatic wait_code(input logic [3:0] exp);
      for (int k = 0; k < 40 && code !== exp; k++) begin
         cyc(1);
      end
      chk(code, exp);
   endtask
   task automatic to_prechg();
      vbat <= 16'h0af0;
      tmr <= 3'h0;
      temp_dis <= 1'b0;
      cfg.charger_enable <= 1'b0;
      wait_code(4'h1);
      cfg.charger_enable <= 1'b1;
      wait_code(4'hb);
      wait_code(4'h2);
   endtask
   task automatic t_boot();
      @(posedge clk);
      link_conn <= 1'b1;
      line_pwr <= 1'b1;
      wait_code(4'h1);
      link_conn <= 1'b0;
      link_idle <= 1'b1;
      cfg <= 6'h31;
      cyc(6);
      chk(code, 4'h1);
      chk({3'h0, lexit}, 4'h1);
      link_idle <= 1'b0;
      wait_code(4'hb);
      chk({2'h0, tres, rres}, 4'h3);
      wait_code(4'h2);
      chk({2'h0, cur}, 4'h1);
      cyc(8);
      chk(code, 4'h2);
      $display("t_boot done");
   endtask
   task automatic t_steps();
      cfg.charger_reg_reset_enable <= 1'b0;
      vbat <= 16'h0dac;
      wait_code(4'h3);
      chk({2'h0, cur}, 4'h2);
      vbat <= 16'h0fd2;
      wait_code(4'h4);
      to_prechg();
      vbat <= 16'h0dac;
      wait_code(4'h3);
      vbat <= 16'h0af0;
      wait_code(4'h2);
      chk({3'h0, sdone}, 4'h1);
      vbat <= 16'h0dac;
      wait_code(4'h4);
      $display("t_steps done");
   endtask
   task automatic t_faults();
      logic [3:0] exp [3] = '{4'h8, 4'h9, 4'ha};
      for (int i = 0; i < 3; i++) begin
         to_prechg();
         tmr <= {i == 0, i == 1, 1'b0};
         temp_dis <= (i == 2);
         wait_code(exp[i]);
         chk({2'h0, cur}, 4'h0);
      end
      $display("t_faults done");
   endtask
   task automatic t_force();
      to_prechg();
      cfg.force_precharge <= 1'b1;
      wait_code(4'hc);
      vbat <= 16'h0dac;
      cyc(4);
      chk(code, 4'hc);
      chk({2'h0, cur}, 4'h1);
      cfg.force_precharge <= 1'b0;
      wait_code(4'hb);
      $display("t_force done");
   endtask
   task automatic t_modes();
      sen_wd <= 1'b0;
      sen_wr <= 1'b1;
      cyc(1);
      sen_wr <= 1'b0;
      cyc(1);
      chk({3'h0, sen}, 4'h0);
      to_prechg();
      vbat <= 16'h0dac;
      wait_code(4'h4);
      sen_wd <= 1'b1;
      sen_wr <= 1'b1;
      rom_wd <= 1'b1;
      rom_wr <= 1'b1;
      zone <= cesf_pkg::CESF_ZONE_COOL;
      cyc(1);
      sen_wr <= 1'b0;
      rom_wr <= 1'b0;
      to_prechg();
      chk({2'h0, sen, rom}, 4'h3);
      vbat <= 16'h0dac;
      wait_code(4'h4);
      zone <= cesf_pkg::CESF_ZONE_ROOM;
      to_prechg();
      vbat <= 16'h0dac;
      wait_code(4'h3);
      zone <= cesf_pkg::CESF_ZONE_WARM;
      wait_code(4'h4);
      zone <= cesf_pkg::CESF_ZONE_ROOM;
      cfg.first_stage_timeout_enable <= 1'b1;
      to_prechg();
      vbat <= 16'h0dac;
      wait_code(4'h3);
      tmr.step_charge_timer <= 1'b1;
      wait_code(4'h4);
      $display("t_modes done");
   endtask
   // Battery above the recharge level: only the skip bit may start boot
   task automatic t_skip();
      cfg.charger_enable <= 1'b0;
      cfg.charger_reg_reset_enable <= 1'b1;
      vbat <= 16'h1036;
      wait_code(4'h1);
      cfg.charger_enable <= 1'b1;
      cyc(6);
      chk(code, 4'h1);
      cfg.skip_recharge_start <= 1'b1;
      wait_code(4'hb);
      chk({2'h0, sen, rom}, 4'h2);
      $display("t_skip done");
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test();
   end
   initial begin
      {srst, link_conn, line_pwr, link_idle, temp_dis} = 5'h10;
      {sen_wr, sen_wd, rom_wr, rom_wd} = 4'h0;
      {cfg, tmr} = 9'h000;
      zone = cesf_pkg::CESF_ZONE_ROOM;
      vbat = 16'h0af0;
      vsys = 16'h0e74;
      cyc(5);
      chk(code, 4'h0);
      chk({2'h0, sen, rom}, 4'h2);
      srst <= 1'b0;
      $display("t_reset done");
      t_boot();
      t_steps();
      t_faults();
      t_force();
      t_modes();
      t_skip();
      stop_test();
   end
endmodule
`default_nettype wire
